// ==== core/swsm_defs.svh ====
// Constants of the slave watchdog and state machine block.
`ifndef SWSM_DEFS_SVH
`define SWSM_DEFS_SVH
// Clock period and watchdog base period in ns.
`define SWSM_CLK_NS        50
`define SWSM_BASE_NS       40
// Reset values of the watchdog settings, and the addend to the multiplier.
`define SWSM_MULT_RST      16'h09C2
`define SWSM_MULT_ADD      16'h0002
`define SWSM_SM_CNT_RST    16'h03E8
`define SWSM_PDI_CNT_RST   16'h03E8
// Register byte offsets of the master end.
`define SWSM_CTRL_OFS      8'h00
`define SWSM_CFG_OFS       8'h04
`define SWSM_PDOUT_OFS     8'h08
`define SWSM_MBX_OFS       8'h0C
`define SWSM_STAT_OFS      8'h10
// Control register fields.
`define SWSM_CTRL_GO       3
`define SWSM_CTRL_MANUAL   4
`define SWSM_CTRL_MBXOK    5
`define SWSM_CTRL_PDOK     6
`define SWSM_CTRL_DCOK     7
`define SWSM_CTRL_SMEN     8
`define SWSM_CTRL_PDIEN    9
`define SWSM_CTRL_RST      32'h0000_0300
// Status register fields.
`define SWSM_STAT_ERR      3
`define SWSM_STAT_REFUSE   4
`define SWSM_STAT_MBXACK   5
`define SWSM_STAT_MBXREJ   6
`define SWSM_STAT_SMEXP    7
`define SWSM_STAT_PDIEXP   8
`define SWSM_STAT_OUTVAL   9
`endif

// ==== core/swsm_pkg.sv ====
// Types shared by both ends of the slave watchdog and state machine block.
package swsm_pkg;
   typedef enum logic [2:0] {ST_INIT, ST_PREOP, ST_SAFEOP, ST_OP, ST_BOOT} swsm_state_e;
   typedef enum logic [1:0] {CFG_MULT, CFG_SM_CNT, CFG_PDI_CNT} swsm_cfg_e;
endpackage : swsm_pkg

// ==== core/swsm_link_if.sv ====
// Link between the fieldbus master end and the slave controller end.
`timescale 1ns/1ns
interface swsm_link_if;
   import swsm_pkg::*;
   logic              req_valid;
   swsm_state_e       req_state;
   swsm_state_e       cur_state;
   logic              state_ack;
   logic              state_err;
   logic              mbx_cfg_ok;
   logic              pd_cfg_ok;
   logic              dc_ok;
   logic              pd_valid;
   logic [7:0]        pd_out;
   logic              pd_ok;
   logic [7:0]        pd_in;
   logic              mbx_valid;
   logic              mbx_foe;
   logic              mbx_ack;
   logic              mbx_rej;
   logic              cfg_valid;
   swsm_cfg_e         cfg_sel;
   logic [15:0]       cfg_data;
   logic              sm_wd_en;
   logic              pdi_wd_en;
   logic              sm_expired;
   logic              pdi_expired;

   modport master_mp (
      output req_valid, req_state, mbx_cfg_ok, pd_cfg_ok, dc_ok, pd_valid, pd_out,
             mbx_valid, mbx_foe, cfg_valid, cfg_sel, cfg_data, sm_wd_en, pdi_wd_en,
      input  cur_state, state_ack, state_err, pd_ok, pd_in, mbx_ack, mbx_rej,
             sm_expired, pdi_expired
   );
   modport slave_mp (
      input  req_valid, req_state, mbx_cfg_ok, pd_cfg_ok, dc_ok, pd_valid, pd_out,
             mbx_valid, mbx_foe, cfg_valid, cfg_sel, cfg_data, sm_wd_en, pdi_wd_en,
      output cur_state, state_ack, state_err, pd_ok, pd_in, mbx_ack, mbx_rej,
             sm_expired, pdi_expired
   );
endinterface : swsm_link_if

// ==== core/swsm_wd_timer.sv ====
// One supervision timer counting shared watchdog ticks.
`timescale 1ns/1ns
module swsm_wd_timer (
   // Clock and reset.
   input  wire logic        hclk,
   input  wire logic        hresetn,
   // Tick, restart and setting.
   input  wire logic        tick,
   input  wire logic        kick,
   input  wire logic        enable,
   input  wire logic [15:0] limit,
   // Expiry flag, held until the next restart, a disable or a zero limit.
   output logic             expired
);
   logic [15:0] cnt_q;
   logic        expired_q;

   // Counts ticks since the last restart and trips at the limit.
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         cnt_q     <= 16'h0000;
         expired_q <= 1'b0;
      end
      else if (kick || !enable || limit == 16'h0000)
      begin
         cnt_q     <= 16'h0000;
         expired_q <= 1'b0;
      end
      else if (tick && !expired_q)
      begin
         cnt_q <= cnt_q + 16'h0001;
         if (cnt_q + 16'h0001 >= limit)
            expired_q <= 1'b1;
      end
   end

   // The flag leaves straight from its flip-flop.
   assign expired = expired_q;
endmodule : swsm_wd_timer

// ==== core/swsm_slave.sv ====
// Slave controller end: watchdogs, tick prescaler and slave state machine.
`timescale 1ns/1ns
`include "swsm_defs.svh"
module swsm_slave (
   // Clock and reset.
   input  wire logic             hclk,
   input  wire logic             hresetn,
   // Link to the fieldbus master.
   swsm_link_if.slave_mp         link,
   // Application side.
   input  wire logic             app_access,
   input  wire logic [7:0]       phys_in,
   output logic [7:0]            phys_out,
   output swsm_pkg::swsm_state_e app_state,
   output logic                  sm_wd_trip,
   output logic                  pdi_wd_trip
);
   import swsm_pkg::*;

   swsm_state_e  state_q;
   logic         err_q;
   logic         ack_q;
   logic [15:0]  mult_q;
   logic [15:0]  sm_cnt_q;
   logic [15:0]  pdi_cnt_q;
   logic [22:0]  pre_acc_q;
   logic [22:0]  pre_period;
   logic [22:0]  pre_next;
   logic         tick;
   logic [7:0]   in_meta_q;
   logic [7:0]   in_sync_q;
   logic [7:0]   in_q;
   logic [7:0]   out_q;
   logic [7:0]   phys_out_q;
   logic         pd_ok;
   logic         mbx_ok;
   logic         sm_exp;
   logic         pdi_exp;
   logic         req_pass;

   // Tells whether a move between two states is permitted at all.
   function automatic logic legal_move(input swsm_state_e from, input swsm_state_e to);
      logic ok;
      ok = 1'b0;
      case (to)
         ST_INIT:   ok = 1'b1;
         ST_PREOP:  ok = (from == ST_INIT) || (from == ST_SAFEOP) || (from == ST_OP);
         ST_SAFEOP: ok = (from == ST_PREOP) || (from == ST_OP);
         ST_OP:     ok = (from == ST_SAFEOP);
         ST_BOOT:   ok = (from == ST_INIT);
         default:   ok = 1'b0;
      endcase
      return ok;
   endfunction : legal_move

   // Settings downloaded by the master; a zero multiplier is ignored.
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         mult_q    <= `SWSM_MULT_RST;
         sm_cnt_q  <= `SWSM_SM_CNT_RST;
         pdi_cnt_q <= `SWSM_PDI_CNT_RST;
      end
      else if (link.cfg_valid)
      begin
         case (link.cfg_sel)
            CFG_MULT:
            begin
               if (link.cfg_data != 16'h0000)
                  mult_q <= link.cfg_data;
            end
            CFG_SM_CNT:  sm_cnt_q  <= link.cfg_data;
            CFG_PDI_CNT: pdi_cnt_q <= link.cfg_data;
            default:     mult_q    <= mult_q;
         endcase
      end
   end

   // One tick spans (multiplier + 2) base periods; the accumulator keeps the
   // average exact although the system clock period differs from the base.
   assign pre_period = 23'((23'(mult_q) + 23'(`SWSM_MULT_ADD)) * 23'(`SWSM_BASE_NS));
   assign pre_next   = pre_acc_q + 23'(`SWSM_CLK_NS);
   assign tick       = (pre_next >= pre_period);

   // Prescaler shared by both timers.
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
         pre_acc_q <= 23'h000000;
      else if (tick)
         pre_acc_q <= pre_next - pre_period;
      else
         pre_acc_q <= pre_next;
   end

   // Fieldbus timer, restarted only by accepted process data.
   swsm_wd_timer u_sm_wd (
      .hclk    (hclk),
      .hresetn (hresetn),
      .tick    (tick),
      .kick    (pd_ok),
      .enable  (link.sm_wd_en),
      .limit   (sm_cnt_q),
      .expired (sm_exp)
   );

   // Local interface timer, restarted by any application access.
   swsm_wd_timer u_pdi_wd (
      .hclk    (hclk),
      .hresetn (hresetn),
      .tick    (tick),
      .kick    (app_access),
      .enable  (link.pdi_wd_en),
      .limit   (pdi_cnt_q),
      .expired (pdi_exp)
   );

   // Input pins pass two flip-flops before use.
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         in_meta_q <= 8'h00;
         in_sync_q <= 8'h00;
      end
      else
      begin
         in_meta_q <= phys_in;
         in_sync_q <= in_meta_q;
      end
   end

   // Checks of the current request: transition legal and setup verified.
   always_comb
   begin
      req_pass = legal_move(state_q, link.req_state);
      if (state_q == ST_INIT && link.req_state == ST_PREOP)
         req_pass = req_pass && link.mbx_cfg_ok;
      if (state_q == ST_PREOP && link.req_state == ST_SAFEOP)
         req_pass = req_pass && link.pd_cfg_ok && link.dc_ok;
   end

   // Slave state machine; watchdog expiry has no effect on it.
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         state_q <= ST_INIT;
         err_q   <= 1'b0;
         ack_q   <= 1'b0;
      end
      else
      begin
         ack_q <= link.req_valid;
         if (link.req_valid && link.req_state != state_q)
         begin
            if (req_pass)
            begin
               state_q <= link.req_state;
               err_q   <= 1'b0;
            end
            else
               err_q <= 1'b1;
         end
         else if (link.req_valid)
            err_q <= 1'b0;
      end
   end

   // Traffic gating per state.
   always_comb
   begin
      case (state_q)
         ST_PREOP:  mbx_ok = 1'b1;
         ST_SAFEOP: mbx_ok = 1'b1;
         ST_OP:     mbx_ok = 1'b1;
         ST_BOOT:   mbx_ok = link.mbx_foe;
         default:   mbx_ok = 1'b0;
      endcase
   end
   assign pd_ok = link.pd_valid && (state_q == ST_SAFEOP || state_q == ST_OP);

   // Input image: copied on entry to Safe-Op from Pre-Op and on each exchange.
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
         in_q <= 8'h00;
      else if (link.req_valid && req_pass && state_q == ST_PREOP && link.req_state == ST_SAFEOP)
         in_q <= in_sync_q;
      else if (pd_ok)
         in_q <= in_sync_q;
   end

   // Output image taken from the master only in Op.
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
         out_q <= 8'h00;
      else if (pd_ok && state_q == ST_OP)
         out_q <= link.pd_out;
   end

   // Physical outputs: live in Op, false in all other states or on fieldbus timer expiry.
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
         phys_out_q <= 8'h00;
      else if (state_q == ST_OP && !sm_exp)
         phys_out_q <= out_q;
      else
         phys_out_q <= 8'h00;
   end

   // Answers towards the master and the application.
   assign phys_out         = phys_out_q;
   assign app_state        = state_q;
   assign sm_wd_trip       = sm_exp;
   assign pdi_wd_trip      = pdi_exp;
   assign link.cur_state   = state_q;
   assign link.state_ack   = ack_q;
   assign link.state_err   = err_q;
   assign link.pd_ok       = pd_ok;
   assign link.pd_in       = in_q;
   assign link.mbx_ack     = link.mbx_valid && mbx_ok;
   assign link.mbx_rej     = link.mbx_valid && !mbx_ok;
   assign link.sm_expired  = sm_exp;
   assign link.pdi_expired = pdi_exp;
endmodule : swsm_slave

// ==== core/swsm_master.sv ====
// Fieldbus master end, ordered by software over AHB-Lite.
`timescale 1ns/1ns
`include "swsm_defs.svh"
module swsm_master (
   // Clock and reset.
   input  wire logic        hclk,
   input  wire logic        hresetn,
   // AHB-Lite slave port.
   input  wire logic        hsel,
   input  wire logic [31:0] haddr,
   input  wire logic [1:0]  htrans,
   input  wire logic        hwrite,
   input  wire logic [2:0]  hsize,
   input  wire logic [31:0] hwdata,
   input  wire logic        hready,
   output logic             hreadyout,
   output logic             hresp,
   output logic [31:0]      hrdata,
   // Link to the slave controller.
   swsm_link_if.master_mp   link
);
   import swsm_pkg::*;

   logic        dp_sel_q;
   logic        dp_wr_q;
   logic [7:0]  dp_addr_q;
   logic [31:0] ctrl_q;
   logic        req_valid_q;
   swsm_state_e req_state_q;
   logic        pd_valid_q;
   logic [7:0]  pd_out_q;
   logic        mbx_valid_q;
   logic        mbx_foe_q;
   logic        cfg_valid_q;
   swsm_cfg_e   cfg_sel_q;
   logic [15:0] cfg_data_q;
   logic        out_valid_q;
   logic        refuse_q;
   logic        mbx_ack_q;
   logic        mbx_rej_q;
   logic        wr_ctrl;
   logic        wr_cfg;
   logic        wr_stat;
   logic        go_bad;
   logic        cfg_bad;

   // Address phase capture; every transfer ends with no wait state.
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         dp_sel_q  <= 1'b0;
         dp_wr_q   <= 1'b0;
         dp_addr_q <= 8'h00;
      end
      else if (hready)
      begin
         dp_sel_q  <= hsel && htrans[1];
         dp_wr_q   <= hwrite;
         dp_addr_q <= haddr[7:0];
      end
   end

   // Write strobes and refusals of the data phase.
   assign wr_ctrl = dp_sel_q && dp_wr_q && dp_addr_q == `SWSM_CTRL_OFS;
   assign wr_cfg  = dp_sel_q && dp_wr_q && dp_addr_q == `SWSM_CFG_OFS;
   assign wr_stat = dp_sel_q && dp_wr_q && dp_addr_q == `SWSM_STAT_OFS;
   assign go_bad  = wr_ctrl && hwdata[`SWSM_CTRL_GO] && swsm_state_e'(hwdata[2:0]) == ST_OP
                    && !out_valid_q;
   assign cfg_bad = wr_cfg && !(ctrl_q[`SWSM_CTRL_MANUAL] && link.cur_state == ST_INIT);

   // Control register and state requests.
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         ctrl_q      <= `SWSM_CTRL_RST;
         req_valid_q <= 1'b0;
         req_state_q <= ST_INIT;
      end
      else
      begin
         req_valid_q <= wr_ctrl && hwdata[`SWSM_CTRL_GO] && !go_bad;
         if (wr_ctrl)
         begin
            ctrl_q      <= hwdata & 32'h0000_03F7;
            req_state_q <= swsm_state_e'(hwdata[2:0]);
         end
      end
   end

   // Settings, process data and mailbox orders, one cycle each.
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         cfg_valid_q <= 1'b0;
         cfg_sel_q   <= CFG_MULT;
         cfg_data_q  <= 16'h0000;
         pd_valid_q  <= 1'b0;
         pd_out_q    <= 8'h00;
         mbx_valid_q <= 1'b0;
         mbx_foe_q   <= 1'b0;
      end
      else
      begin
         cfg_valid_q <= wr_cfg && !cfg_bad;
         pd_valid_q  <= dp_sel_q && dp_wr_q && dp_addr_q == `SWSM_PDOUT_OFS;
         mbx_valid_q <= dp_sel_q && dp_wr_q && dp_addr_q == `SWSM_MBX_OFS;
         if (wr_cfg)
         begin
            cfg_sel_q  <= swsm_cfg_e'(hwdata[17:16]);
            cfg_data_q <= hwdata[15:0];
         end
         if (dp_sel_q && dp_wr_q && dp_addr_q == `SWSM_PDOUT_OFS)
            pd_out_q <= hwdata[7:0];
         if (dp_sel_q && dp_wr_q && dp_addr_q == `SWSM_MBX_OFS)
            mbx_foe_q <= hwdata[0];
      end
   end

   // Sticky status flags; a new event wins over a write-one clear.
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         out_valid_q <= 1'b0;
         refuse_q    <= 1'b0;
         mbx_ack_q   <= 1'b0;
         mbx_rej_q   <= 1'b0;
      end
      else
      begin
         if (link.cur_state == ST_INIT)
            out_valid_q <= 1'b0;
         else if (link.pd_ok)
            out_valid_q <= 1'b1;
         refuse_q  <= (go_bad || cfg_bad) || (refuse_q && !(wr_stat && hwdata[`SWSM_STAT_REFUSE]));
         mbx_ack_q <= link.mbx_ack || (mbx_ack_q && !(wr_stat && hwdata[`SWSM_STAT_MBXACK]));
         mbx_rej_q <= link.mbx_rej || (mbx_rej_q && !(wr_stat && hwdata[`SWSM_STAT_MBXREJ]));
      end
   end

   // Read data loaded at the address phase so it stands from a flop in the data phase;
   // a register written in an overlapping data phase therefore reads its old value.
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
         hrdata <= 32'h0000_0000;
      else if (hready && hsel && htrans[1] && !hwrite)
      begin
         case (haddr[7:0])
            `SWSM_CTRL_OFS:  hrdata <= ctrl_q | {29'h0000_0000, req_state_q};
            `SWSM_PDOUT_OFS: hrdata <= {24'h00_0000, pd_out_q};
            `SWSM_STAT_OFS:  hrdata <= {8'h00, link.pd_in, 6'h00, out_valid_q, link.pdi_expired,
                                        link.sm_expired, mbx_rej_q, mbx_ack_q, refuse_q,
                                        link.state_err, link.cur_state};
            default:         hrdata <= 32'h0000_0000;
         endcase
      end
      else
         hrdata <= 32'h0000_0000;
   end

   // Bus answer and link drive.
   assign hreadyout       = 1'b1;
   assign hresp           = 1'b0;
   assign link.req_valid  = req_valid_q;
   assign link.req_state  = req_state_q;
   assign link.mbx_cfg_ok = ctrl_q[`SWSM_CTRL_MBXOK];
   assign link.pd_cfg_ok  = ctrl_q[`SWSM_CTRL_PDOK];
   assign link.dc_ok      = ctrl_q[`SWSM_CTRL_DCOK];
   assign link.sm_wd_en   = ctrl_q[`SWSM_CTRL_SMEN];
   assign link.pdi_wd_en  = ctrl_q[`SWSM_CTRL_PDIEN];
   assign link.pd_valid   = pd_valid_q;
   assign link.pd_out     = pd_out_q;
   assign link.mbx_valid  = mbx_valid_q;
   assign link.mbx_foe    = mbx_foe_q;
   assign link.cfg_valid  = cfg_valid_q;
   assign link.cfg_sel    = cfg_sel_q;
   assign link.cfg_data   = cfg_data_q;
endmodule : swsm_master

// ==== dv/swsm_asserts.sv ====
// Concurrent checks on the link between the master end and the slave end.
`timescale 1ns/1ns
module swsm_asserts
   import swsm_pkg::*;
(
   // Clock and reset.
   input wire logic                 hclk,
   input wire logic                 hresetn,
   // State requests.
   input wire logic                 req_valid,
   input wire swsm_pkg::swsm_state_e req_state,
   input wire swsm_pkg::swsm_state_e cur_state,
   input wire logic                 state_ack,
   input wire logic                 state_err,
   input wire logic                 mbx_cfg_ok,
   // Traffic and watchdog.
   input wire logic                 pd_valid,
   input wire logic                 pd_ok,
   input wire logic                 mbx_valid,
   input wire logic                 mbx_foe,
   input wire logic                 mbx_ack,
   input wire logic                 mbx_rej,
   input wire logic                 sm_expired
);
   // All checks run on the one clock and are off in reset.
   default clocking cb @(posedge hclk);
   endclocking
   default disable iff (!hresetn);

   property p_ack;
      state_ack == $past(req_valid);
   endproperty
   a_ack: assert property (p_ack) else $error("state_ack not one cycle after req_valid");
   property p_hold;
      !$past(req_valid) |-> $stable(cur_state);
   endproperty
   a_hold: assert property (p_hold) else $error("state moved without request");
   property p_preop;
      req_valid && cur_state == ST_INIT && req_state == ST_PREOP && !mbx_cfg_ok |=> cur_state == ST_INIT && state_err;
   endproperty
   a_preop: assert property (p_preop) else $error("unchecked move to pre-op");
   property p_boot;
      req_valid && req_state == ST_BOOT && !(cur_state inside {ST_INIT, ST_BOOT}) |=> $stable(cur_state) && state_err;
   endproperty
   a_boot: assert property (p_boot) else $error("boot entered from wrong state");
   property p_skip;
      req_valid && cur_state == ST_PREOP && req_state == ST_OP |=> cur_state == ST_PREOP && state_err;
   endproperty
   a_skip: assert property (p_skip) else $error("illegal move accepted");
   property p_pd;
      pd_valid |-> pd_ok == (cur_state inside {ST_SAFEOP, ST_OP});
   endproperty
   a_pd: assert property (p_pd) else $error("process data gating wrong");
   property p_mbx;
      mbx_valid |-> mbx_ack == (cur_state inside {ST_PREOP, ST_SAFEOP, ST_OP} || (cur_state == ST_BOOT && mbx_foe))
         && mbx_rej == !mbx_ack;
   endproperty
   a_mbx: assert property (p_mbx) else $error("mailbox gating wrong");
   property p_kick;
      pd_ok |=> !sm_expired;
   endproperty
   a_kick: assert property (p_kick) else $error("fieldbus timer not restarted");
   property p_trip;
      $rose(sm_expired) |-> !$past(pd_ok);
   endproperty
   a_trip: assert property (p_trip) else $error("expiry right after exchange");
   c_op: cover property (cur_state == ST_OP);
   c_foe: cover property (mbx_valid && mbx_foe && mbx_ack && cur_state == ST_BOOT);
   c_exp: cover property ($rose(sm_expired));
endmodule : swsm_asserts

// ==== dv/tb_slave_watchdog_state_machine.sv ====
// Self-checking testbench of the master and slave ends joined by their link.
`timescale 1ns/1ns
`define CHK(nm, e, g) begin num_checks++; if ((g) !== (e)) begin n_fail++; $display("CHECK FAILED %s exp %h got %h", nm, e, g); end end
module tb_slave_watchdog_state_machine;
   import swsm_pkg::*;
   logic        hclk = 1'h0, hresetn = 1'h0, hsel = 1'h0, hwrite = 1'h0, app_access = 1'h0, rd_dp = 1'h0;
   logic [1:0]  htrans = 2'h0;
   logic [2:0]  hsize  = 3'h2;
   logic [7:0]  phys_in = 8'h00;
   logic [31:0] haddr = 32'h0, hwdata = 32'h0;
   wire         hreadyout, hresp, sm_wd_trip, pdi_wd_trip;
   wire  [31:0] hrdata;
   wire  [7:0]  phys_out;
   swsm_state_e app_state;
   int          n_fail = 0, num_checks = 0;
   logic [31:0] exp_q[$], msk_q[$];
   swsm_state_e tgt[10] = '{ST_SAFEOP, ST_PREOP, ST_BOOT, ST_PREOP, ST_INIT, ST_PREOP, ST_BOOT, ST_SAFEOP, ST_SAFEOP, ST_OP};
   swsm_state_e st[10]  = '{ST_INIT, ST_INIT, ST_BOOT, ST_BOOT, ST_INIT, ST_PREOP, ST_PREOP, ST_PREOP, ST_SAFEOP, ST_OP};
   logic [2:0]  ok[10]  = '{3'h0, 3'h0, 3'h0, 3'h1, 3'h0, 3'h1, 3'h1, 3'h3, 3'h7, 3'h7};
   logic        er[10]  = '{1'h1, 1'h1, 1'h0, 1'h1, 1'h0, 1'h0, 1'h1, 1'h1, 1'h0, 1'h0};

   // Free-running bus clock.
   always #25 hclk = ~hclk;

   swsm_link_if swsm_link_if_inst ();
   swsm_master swsm_master_inst (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
      .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp),
      .hrdata(hrdata), .link(swsm_link_if_inst));
   swsm_slave swsm_slave_inst (.hclk(hclk), .hresetn(hresetn), .link(swsm_link_if_inst), .app_access(app_access),
      .phys_in(phys_in), .phys_out(phys_out), .app_state(app_state), .sm_wd_trip(sm_wd_trip),
      .pdi_wd_trip(pdi_wd_trip));
   swsm_asserts swsm_asserts_inst (.hclk(hclk), .hresetn(hresetn), .req_valid(swsm_link_if_inst.req_valid),
      .req_state(swsm_link_if_inst.req_state), .cur_state(swsm_link_if_inst.cur_state),
      .state_ack(swsm_link_if_inst.state_ack), .state_err(swsm_link_if_inst.state_err),
      .mbx_cfg_ok(swsm_link_if_inst.mbx_cfg_ok), .pd_valid(swsm_link_if_inst.pd_valid),
      .pd_ok(swsm_link_if_inst.pd_ok), .mbx_valid(swsm_link_if_inst.mbx_valid), .mbx_foe(swsm_link_if_inst.mbx_foe),
      .mbx_ack(swsm_link_if_inst.mbx_ack), .mbx_rej(swsm_link_if_inst.mbx_rej),
      .sm_expired(swsm_link_if_inst.sm_expired));

   // Prints the verdict and ends the run.
   task automatic close_out();
      if (n_fail == 0 && num_checks > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask : close_out

   // One single AHB transfer; a read notes its masked expectation for the monitor.
   task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [31:0] m);
      haddr <= {24'h0, a};
      hwrite <= w;
      htrans <= 2'h2;
      hsel <= 1'h1;
      do @(posedge hclk); while (hreadyout !== 1'h1);
      htrans <= 2'h0;
      hwdata <= w ? d : 32'h0;
      if (!w)
      begin
         exp_q.push_back(d & m);
         msk_q.push_back(m);
      end
      do @(posedge hclk); while (hreadyout !== 1'h1);
   endtask : xfer

   // Lets a fixed number of clock edges pass.
   task automatic idle(input int n);
      repeat (n) @(posedge hclk);
   endtask : idle

   // Compares each read's data with the oldest noted expectation.
   always @(posedge hclk)
   begin
      if (rd_dp && hreadyout === 1'h1)
      begin
         `CHK("hrdata", exp_q[0], hrdata & msk_q[0])
         void'(exp_q.pop_front());
         void'(msk_q.pop_front());
      end
      rd_dp <= hsel && htrans[1] && !hwrite && hreadyout;
   end

   // Cuts a hung run short.
   initial
   begin
      #(4000 * 50);
      n_fail++;
      close_out();
   end

   // Main sequence.
   initial
   begin
      logic [7:0] pd;
      logic       foe;
      logic       ack;
      void'($urandom(32'h73A23923));
      phys_in <= 8'($urandom);
      idle(3);
      hresetn <= 1'h1;
      idle(1);
      xfer(0, 8'h00, 32'h300, 32'h3FF);
      xfer(0, 8'h10, 32'h0, 32'h1FF);
      xfer(0, 8'h14, 32'h0, 32'hFFFFFFFF);
      xfer(1, 8'h00, 32'h310, 0);
      xfer(1, 8'h04, 32'h00000001, 0);
      xfer(1, 8'h04, 32'h00010006 + ($urandom % 4), 0);
      xfer(1, 8'h04, 32'h00020004 + ($urandom % 4), 0);
      app_access <= 1'h1;
      for (int i = 0; i < 10; i++)
      begin
         xfer(1, 8'h00, 32'h318 | {24'h0, ok[i], 5'h0} | {29'h0, tgt[i]}, 0);
         idle(3);
         foe = 1'($urandom);
         xfer(1, 8'h0C, {31'h0, foe}, 0);
         idle(2);
         ack = (st[i] inside {ST_PREOP, ST_SAFEOP, ST_OP}) || (st[i] == ST_BOOT && foe);
         xfer(0, 8'h10, {25'h0, !ack, ack, 1'h0, er[i], st[i]}, 32'h6F);
         xfer(1, 8'h10, 32'h70, 0);
         pd = 8'($urandom);
         xfer(1, 8'h08, {24'h0, pd}, 0);
         idle(4);
         `CHK("phys_out", (st[i] == ST_OP) ? pd : 8'h00, phys_out)
         `CHK("app_state", st[i], app_state)
      end
      idle(40);
      xfer(0, 8'h10, {8'h0, phys_in, 16'h0083}, 32'hFF0087);
      `CHK("phys_out", 8'h00, phys_out)
      xfer(1, 8'h08, {24'h0, pd}, 0);
      idle(4);
      `CHK("phys_out", pd, phys_out)
      app_access <= 1'h0;
      idle(40);
      xfer(0, 8'h10, 32'h100, 32'h100);
      app_access <= 1'h1;
      idle(3);
      xfer(0, 8'h10, 32'h0, 32'h100);
      xfer(1, 8'h00, 32'h308, 0);
      xfer(1, 8'h04, 32'h00010000, 0);
      idle(2);
      xfer(0, 8'h10, 32'h10, 32'h1F);
      xfer(1, 8'h00, 32'h310, 0);
      xfer(1, 8'h04, 32'h00010000, 0);
      xfer(1, 8'h10, 32'h70, 0);
      idle(40);
      xfer(0, 8'h10, 32'h0, 32'h9F);
      xfer(1, 8'h00, 32'h30B, 0);
      idle(2);
      xfer(0, 8'h10, 32'h10, 32'h1F);
      idle(2);
      close_out();
   end
endmodule : tb_slave_watchdog_state_machine
